// ---- fws_pkg.sv ----
// Constants shared by the failsafe watchdog supervisor.
package fws_pkg;

  // Clock rate and interval figures.
  localparam int unsigned CLOCK_MHZ          = 250;
  localparam int unsigned WATCH_INTERVAL_MS  = 10;
  localparam int unsigned WATCH_INTERVAL_CYC = WATCH_INTERVAL_MS * 1000 * CLOCK_MHZ;
  localparam int unsigned FILTER_DIVISOR     = 32;
  localparam int unsigned KICK_MIN_NS        = 150;
  localparam int unsigned CLOCK_PERIOD_NS    = 1000 / CLOCK_MHZ;
  localparam int unsigned KICK_MIN_CYC       = (KICK_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // Synchroniser depth for pin inputs.
  localparam int unsigned SYNC_DEPTH = 3;

  // Supervisor states.
  typedef enum logic [2:0]
  {
    FWS_OFF,
    FWS_FILTER,
    FWS_POR,
    FWS_RUN,
    FWS_EXPIRED,
    FWS_HALT
  } fws_state_t;

endpackage

// ---- fws_supervisor.sv ----
// Failsafe watchdog supervisor with supply-monitor sequencing.
`timescale 1ns/10ps

// Overview of operation
// [R1] Start power-on sequence only with input above upper level and core armed.
// [R2] Below warn level assert warning; below lower level assert hold-low.
// [R3] Unserviced watchdog warns after first interval, holds after second, stays held until a falling kick.
// [R4] Default watch interval 10 ms, also used as power-on reset delay.
// [R5] Power-on condition filtered for one thirty-second of the interval.
// [R6] Core below arm level: supervision off, warning and hold-low driven low.
// [R7] Core armed: outputs follow watchdog timer and monitored input levels.
// [R8] Core below drop level: timer and supervision off, warning and hold-low driven low, expiry warning high.
// [R9] Falling kick restarts interval from zero and sets expiry warning high.
// [R10] Expiry warning toggles each interval from high; hold-low at first low end.
// [R11] Hold-low released one interval after the filtered upper-level condition; kicks ignored meanwhile.
// [R12] Below lower level forces outputs low, expiry off, kicks ignored until power-up.
// [R13] Interval measured by counting cycles up to a parameterised terminal count.
// [R14] Comparator results and kick synchronised; kick detected as falling edge.
module fws_supervisor
  import fws_pkg::*;
#(
  parameter int unsigned INTERVAL_CYC = WATCH_INTERVAL_CYC // Watch interval in cycles.
)
(
  input  wire logic clock,            // 250 MHz clock.
  input  wire logic rst_n,            // Asynchronous reset, active low.
  input  wire logic above_upper_trip, // Monitored input above upper trip level.
  input  wire logic above_warn_trip,  // Monitored input above warn trip level.
  input  wire logic above_lower_trip, // Monitored input above lower trip level.
  input  wire logic core_above_arm,   // Core supply above arm level.
  input  wire logic core_above_drop,  // Core supply above drop level.
  input  wire logic kick_n,           // Watchdog service input, active low.
  output logic      expiry_warn_n,    // Expiry warning, active low.
  output logic      power_fail_n,     // Power-fail warning, active low.
  output logic      system_hold_n     // System hold output, active low.
);

  localparam int unsigned FILTER_CYC = (INTERVAL_CYC / FILTER_DIVISOR > 0) ?
                                       INTERVAL_CYC / FILTER_DIVISOR : 1;
  localparam int unsigned CW = $clog2(INTERVAL_CYC + 1);
  localparam int unsigned NS = 5;

  // Refuse an interval too short to filter or count, when the design is elaborated.
  if (INTERVAL_CYC < 2)
  begin : g_bad_interval
    $error("fws_supervisor: INTERVAL_CYC must be at least 2");
  end

  //////////////////////////////////////////////////////////////////////////////

  logic [NS-1:0] sync_in;
  logic [NS-1:0] s1_q, s2_q, s3_q;
  logic [NS-1:0] s1_d, s2_d, s3_d;
  logic [NS-1:0] clean_q, clean_d;

  assign sync_in = {kick_n, core_above_drop, core_above_arm, above_lower_trip,
                    above_upper_trip};

  // Three-stage synchroniser; a change is taken once stages two and three agree.
  always_comb
  begin
    s1_d    = sync_in;
    s2_d    = s1_q;
    s3_d    = s2_q;
    clean_d = clean_q;
    for (int i = 0; i < NS; i++)
    begin
      if (s2_q[i] == s3_q[i])
        clean_d[i] = s3_q[i]; // [R14]
    end
  end

  // Synchroniser registers; comparators rest at the low, unpowered level and the kick
  // line at its idle high level in every stage, so that no false kick edge follows reset.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q    <= {1'b1, {(NS-1){1'b0}}};
      s2_q    <= {1'b1, {(NS-1){1'b0}}};
      s3_q    <= {1'b1, {(NS-1){1'b0}}};
      clean_q <= {1'b1, {(NS-1){1'b0}}};
    end
    else
    begin
      s1_q    <= s1_d;
      s2_q    <= s2_d;
      s3_q    <= s3_d;
      clean_q <= clean_d;
    end
  end

  // Warn comparator synchronised separately to keep the vector compact.
  logic w1_q, w2_q, w3_q, warn_q;
  logic w1_d, w2_d, w3_d, warn_d;

  // Next values for the warn comparator synchroniser.
  always_comb
  begin
    w1_d   = above_warn_trip;
    w2_d   = w1_q;
    w3_d   = w2_q;
    warn_d = (w2_q == w3_q) ? w3_q : warn_q; // [R14]
  end

  // Warn comparator synchroniser registers.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w1_q   <= 1'b0;
      w2_q   <= 1'b0;
      w3_q   <= 1'b0;
      warn_q <= 1'b0;
    end
    else
    begin
      w1_q   <= w1_d;
      w2_q   <= w2_d;
      w3_q   <= w3_d;
      warn_q <= warn_d;
    end
  end

  logic upper_s, lower_s, arm_s, drop_s, kick_s;
  assign upper_s = clean_q[0];
  assign lower_s = clean_q[1];
  assign arm_s   = clean_q[2];
  assign drop_s  = clean_q[3];
  assign kick_s  = clean_q[4];

  //////////////////////////////////////////////////////////////////////////////

  fws_state_t    state_q, state_d;
  logic [CW-1:0] count_q, count_d;
  logic          kick_prev_q, kick_prev_d;
  logic          armed_q, armed_d;
  logic          save_q, save_d;
  logic          toe_q, toe_d;
  logic          hold_q, hold_d;
  logic          kick_fall;
  logic          interval_done;
  logic          filter_done;

  assign kick_fall     = kick_prev_q & ~kick_s; // [R14]
  assign interval_done = (count_q == CW'(INTERVAL_CYC - 1)); // [R13]
  assign filter_done   = (count_q == CW'(FILTER_CYC - 1)); // [R5]

  // Sequencer: supply arming, power-on delay, watchdog and failsafe halt.
  always_comb
  begin
    state_d     = state_q;
    count_d     = count_q + CW'(1); // [R13]
    kick_prev_d = kick_s;
    armed_d     = armed_q;
    save_d      = save_q;
    toe_d       = toe_q;
    hold_d      = hold_q;
    if (arm_s)
      armed_d = 1'b1;
    if (!drop_s)
      armed_d = 1'b0;
    if (!armed_q)
    begin
      state_d = FWS_OFF; // [R6] [R8]
      count_d = '0;
      save_d  = 1'b0;
      hold_d  = 1'b0;
      toe_d   = 1'b1;
    end
    else if (!lower_s && state_q != FWS_OFF && state_q != FWS_FILTER)
    begin
      state_d = FWS_OFF; // [R12] [R2]
      count_d = '0;
      save_d  = 1'b0;
      hold_d  = 1'b0;
      toe_d   = 1'b1;
    end
    else
    begin
      // Power-fail warning follows the input with hysteresis. [R2] [R7]
      if (!warn_q)
        save_d = 1'b0;
      else if (upper_s && state_q != FWS_OFF && state_q != FWS_FILTER)
        save_d = 1'b1;
      case (state_q)
        FWS_OFF:
        begin
          count_d = '0;
          if (upper_s)
            state_d = FWS_FILTER; // [R1]
        end
        FWS_FILTER:
        begin
          if (!upper_s)
          begin
            state_d = FWS_OFF;
            count_d = '0;
          end
          else if (filter_done)
          begin
            state_d = FWS_POR; // [R5]
            count_d = '0;
            save_d  = warn_q;
          end
        end
        FWS_POR:
        begin
          if (interval_done)
          begin
            state_d = FWS_RUN; // [R11] [R4]
            count_d = '0;
            hold_d  = 1'b1;
          end
        end
        FWS_RUN, FWS_EXPIRED, FWS_HALT:
        begin
          if (kick_fall)
          begin
            state_d = FWS_RUN; // [R9]
            count_d = '0;
            toe_d   = 1'b1;
            hold_d  = 1'b1;
          end
          else if (interval_done)
          begin
            count_d = '0;
            toe_d   = ~toe_q; // [R10] [R3]
            if (state_q == FWS_RUN)
              state_d = FWS_EXPIRED;
            else if (state_q == FWS_EXPIRED)
            begin
              state_d = FWS_HALT; // [R3] [R10]
              hold_d  = 1'b0;
            end
          end
        end
        default:
        begin
          state_d = FWS_OFF;
          count_d = '0;
        end
      endcase
    end
  end

  // Sequencer registers.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= FWS_OFF;
      count_q     <= '0;
      kick_prev_q <= 1'b1;
      armed_q     <= 1'b0;
      save_q      <= 1'b0;
      toe_q       <= 1'b1;
      hold_q      <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      count_q     <= count_d;
      kick_prev_q <= kick_prev_d;
      armed_q     <= armed_d;
      save_q      <= save_d;
      toe_q       <= toe_d;
      hold_q      <= hold_d;
    end
  end

  // Outputs come straight from registers.
  assign expiry_warn_n = toe_q;
  assign power_fail_n  = save_q;
  assign system_hold_n = hold_q;

endmodule

// ---- fws_supervisor_checker.sv ----
// Port-level assertions for the failsafe watchdog supervisor.
`timescale 1ns/10ps
module fws_supervisor_checker
  import fws_pkg::*;
#(
  parameter int unsigned INTERVAL_CYC = WATCH_INTERVAL_CYC // Watch interval.
)
(
  input wire logic clock,            // Clock.
  input wire logic rst_n,            // Reset.
  input wire logic above_upper_trip, // Watched.
  input wire logic above_warn_trip,  // Watched.
  input wire logic above_lower_trip, // Watched.
  input wire logic core_above_arm,   // Watched.
  input wire logic core_above_drop,  // Watched.
  input wire logic kick_n,           // Watched.
  input wire logic expiry_warn_n,    // Watched.
  input wire logic power_fail_n,     // Watched.
  input wire logic system_hold_n     // Watched.
);
  logic        arm_q;
  logic [31:0] gap_q;
  logic [31:0] up_q;
  logic [31:0] age_q;
  logic [31:0] calm_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Arm memory and cycle ages that the timing checks compare.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arm_q <= 1'h0;
      gap_q <= 32'h0;
      up_q  <= 32'h0;
      age_q <= 32'h0;
      calm_q <= 32'h0;
    end
    else
    begin
      arm_q <= core_above_arm | (arm_q & core_above_drop);
      gap_q <= $changed(expiry_warn_n) ? 32'h1 : gap_q + 32'h1;
      up_q  <= above_upper_trip ? up_q + 32'h1 : 32'h0;
      age_q <= $rose(power_fail_n) ? 32'h1 : age_q + 32'h1;
      // Cycles since the kick line was last low; separates kick releases from power-on.
      calm_q <= kick_n ? calm_q + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // All checks share one clock and the reset.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_drop; !core_above_drop [*8]; endsequence
  property p_drop; s_drop |-> !power_fail_n && !system_hold_n && expiry_warn_n; endproperty
  a_drop: assert property (p_drop) else $error("outputs on after core drop");
  property p_lower; !above_lower_trip [*8] |-> !system_hold_n && !power_fail_n; endproperty
  a_lower: assert property (p_lower) else $error("outputs on below lower trip");
  property p_warn; !above_warn_trip [*8] |-> !power_fail_n; endproperty
  a_warn: assert property (p_warn) else $error("no warning below warn trip");
  property p_kick; $fell(kick_n) && system_hold_n |-> ##[1:8] expiry_warn_n; endproperty
  a_kick: assert property (p_kick) else $error("kick did not clear expiry");
  property p_revive; $fell(kick_n) && !expiry_warn_n && above_lower_trip && core_above_drop
    |-> ##[1:8] expiry_warn_n && system_hold_n; endproperty
  a_revive: assert property (p_revive) else $error("kick did not revive system");
  property p_toggle; $changed(expiry_warn_n) && !system_hold_n && above_lower_trip
    && $past(above_lower_trip, 8) && core_above_drop |-> gap_q == INTERVAL_CYC; endproperty
  a_toggle: assert property (p_toggle) else $error("expiry phase length wrong");
  property p_por; $rose(system_hold_n) && age_q <= 2 * INTERVAL_CYC && calm_q > 8
    |-> age_q == INTERVAL_CYC; endproperty
  a_por: assert property (p_por) else $error("power-on delay wrong");
  property p_late; $rose(system_hold_n) && calm_q > 8
    |-> up_q >= INTERVAL_CYC + INTERVAL_CYC / 32; endproperty
  a_late: assert property (p_late) else $error("hold released early");
  property p_arm; $rose(power_fail_n) |-> arm_q && up_q >= INTERVAL_CYC / 32; endproperty
  a_arm: assert property (p_arm) else $error("power-up began unarmed");
endmodule

bind fws_supervisor fws_supervisor_checker #(.INTERVAL_CYC(INTERVAL_CYC)) i_chk
(
  .clock(clock), .rst_n(rst_n), .above_upper_trip(above_upper_trip),
  .above_warn_trip(above_warn_trip), .above_lower_trip(above_lower_trip),
  .core_above_arm(core_above_arm), .core_above_drop(core_above_drop), .kick_n(kick_n),
  .expiry_warn_n(expiry_warn_n), .power_fail_n(power_fail_n), .system_hold_n(system_hold_n)
);

// ---- fws_cpu_model.sv ----
// Processor model that services the watchdog with low pulses.
`timescale 1ns/10ps
module fws_cpu_model
  import fws_pkg::*;
(
  input  wire logic clock,  // Shared clock.
  output logic      kick_n  // Service line, idle high.
);
  // The line idles high between services.
  initial kick_n = 1'h1;
  // One service pulse, never shorter than the minimum width.
  task automatic service();
    @(posedge clock);
    #1 kick_n = 1'h0;
    repeat (KICK_MIN_CYC) @(posedge clock);
    #1 kick_n = 1'h1;
  endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the failsafe watchdog supervisor.
`timescale 1ns/10ps
module testbench
  import fws_pkg::*;
;
  localparam int unsigned IC = 64; // Shortened interval.
  // Each row packs drop, arm, upper, warn, lower over expiry, power-fail, hold.
  localparam logic [7:0] ROWS [7] = '{8'hBC, 8'hDC, 8'hFE, 8'hFF, 8'hCD, 8'hC4, 8'hDC};
  logic       clock       = 1'h0;
  logic       rst_n       = 1'h0;
  logic [4:0] lv          = 5'h00;
  logic       kick_n;
  wire  [2:0] o;
  int         fails       = 0;
  int         checks_done = 0;
  int         n;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, design and processor model.
  always #2 clock = ~clock;
  fws_supervisor #(.INTERVAL_CYC(IC)) i_dut
  (
    .clock(clock), .rst_n(rst_n), .above_upper_trip(lv[2]), .above_warn_trip(lv[1]),
    .above_lower_trip(lv[0]), .core_above_arm(lv[3]), .core_above_drop(lv[4]),
    .kick_n(kick_n), .expiry_warn_n(o[2]), .power_fail_n(o[1]), .system_hold_n(o[0])
  );
  fws_cpu_model i_cpu
  (
    .clock(clock), .kick_n(kick_n)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // Helpers: wait edges, compare outputs, end the run.
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [2:0] exp);
    checks_done++;
    if (o !== exp)
    begin
      fails++;
      $display("mismatch at %0t: outputs %b, expected %b", $time, o, exp);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: level table, then timing, kicks and core drop.
  initial
  begin
    tick(12);
    rst_n = 1'h1;
    chk(3'h4);
    foreach (ROWS[i])
    begin
      lv = ROWS[i][7:3];
      tick(40);
      chk(ROWS[i][2:0]);
    end
    i_cpu.service();
    chk(3'h4);
    lv = 5'h1F;
    n = 0;
    while (o[0] !== 1'h1 && n < 100)
    begin
      tick(1);
      n++;
    end
    checks_done++;
    if (n < IC + IC / 32 || n > IC + IC / 32 + 10)
    begin
      fails++;
      $display("mismatch at %0t: hold released after %0d cycles", $time, n);
    end
    tick(IC + 3);
    chk(3'h3);
    tick(IC);
    chk(3'h6);
    tick(IC);
    chk(3'h2);
    i_cpu.service();
    chk(3'h7);
    tick(15);
    i_cpu.service();
    chk(3'h7);
    lv = 5'h1D;
    tick(10);
    chk(3'h5);
    lv = 5'h1F;
    tick(10);
    chk(3'h7);
    lv = 5'h07;
    tick(10);
    chk(3'h4);
    i_cpu.service();
    chk(3'h4);
    lv = 5'h17;
    tick(100);
    chk(3'h4);
    close_out();
  end
  // Watchdog against a hung run.
  initial
  begin
    #80000;
    fails++;
    close_out();
  end
endmodule
